// file: sscc_pkg.sv
// package: register map, field positions, reset values and carriers
package sscc_pkg;
    // ------------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0]  CTRL_IDX   = 8'h12;  // control register index
    localparam logic [7:0]  CFG_IDX    = 8'h13;  // configuration index
    localparam logic [7:0]  CLKDIV_IDX = 8'h14;  // clock divider index
    localparam logic [7:0]  BUF_IDX    = 8'h04;  // data buffer index
    localparam logic [11:0] CTRL_ADDR   = {2'h0, CTRL_IDX, 2'h0};
    localparam logic [11:0] CFG_ADDR    = {2'h0, CFG_IDX, 2'h0};
    localparam logic [11:0] CLKDIV_ADDR = {2'h0, CLKDIV_IDX, 2'h0};
    localparam logic [11:0] BUF_ADDR    = {2'h0, BUF_IDX, 2'h0};
    // ------------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------------
    localparam int CTL_BUSY  = 7;
    localparam int CTL_CMPL  = 6;
    localparam int CTL_RX_OVERRUN_FLAG  = 5;
    localparam int CTL_WRITE_COLLISION_FLAG  = 4;
    localparam int CTL_MODE_FAULT_FLAG  = 3;
    localparam int CTL_MODE_FAULT_ENABLE = 2;
    localparam int CTL_MSTR  = 1;
    localparam int CTL_EN    = 0;
    // ------------------------------------------------------------------
    // configuration field positions
    // ------------------------------------------------------------------
    localparam int CFG_IRQE = 7;
    localparam int CFG_SPOL = 6;
    localparam int CFG_CHR  = 2;
    localparam int CFG_PHA  = 1;
    localparam int CFG_POL  = 0;
    localparam logic [7:0] CFG_WMASK = 8'hC7;  // bits 5:3 reserved
    // ------------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------------
    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [7:0]  CFG_RST  = 8'h00;
    localparam logic [15:0] BUF_RST  = 16'h0000;
    localparam logic [4:0]  BITS8    = 5'h08;
    localparam logic [4:0]  BITS16   = 5'h10;
    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sclk;  // synchronised serial clock
        logic sel;   // synchronised raw select
        logic sdi;   // synchronised data input
    } sscc_pins_t;
    typedef struct packed {
        logic        done;    // full character received
        logic        start;   // transfer began
        logic        abort;   // select dropped mid character
        logic [15:0] rx;      // received character
    } sscc_evt_t;
endpackage

// file: sscc_shift.sv
// serial shift engine of the slave port
`timescale 1ns/1ps
`default_nettype none
module sscc_shift import sscc_pkg::*; (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire sscc_pins_t  pins,      // synchronised pins
    input  wire logic        active,    // enabled, slave, selected
    input  wire logic        cpol,
    input  wire logic        cpha,
    input  wire logic        chr16,
    input  wire logic        load,      // load transmit word
    input  wire logic [15:0] tx_word,
    output logic             sdo,
    output sscc_evt_t        evt
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [15:0] sh_r, sh_nxt;        // shift register
    logic [4:0]  cnt_r, cnt_nxt;      // bits received
    logic        clk_d_r;             // previous sclk
    logic        act_d_r;             // previous active
    logic        sdo_r, sdo_nxt;
    sscc_evt_t   evt_r, evt_nxt;
    logic        rise, fall, lead, trail, smp, shf;
    logic [4:0]  nbits;

    // ------------------------------------------------------------------
    // edge decode
    // ------------------------------------------------------------------
    always_comb begin
        rise  = pins.sclk & ~clk_d_r;
        fall  = ~pins.sclk & clk_d_r;
        lead  = cpol ? fall : rise;        // active edge [R14]
        trail = cpol ? rise : fall;
        smp   = cpha ? trail : lead;       // sample edge [R13]
        shf   = cpha ? lead : trail;
        nbits = chr16 ? BITS16 : BITS8;    // [R12]
    end

    // next state
    always_comb begin
        sh_nxt  = sh_r;
        cnt_nxt = cnt_r;
        sdo_nxt = sdo_r;
        evt_nxt = '0;
        evt_nxt.rx = evt_r.rx;
        if (!active) begin
            // idle: clock ignored, counter cleared [R19]
            cnt_nxt = 5'h00;
            if (act_d_r && cnt_r != 5'h00) begin
                evt_nxt.abort = 1'b1;      // no load, no flag [R17]
            end
            if (load) begin
                sh_nxt = tx_word;
            end
            sdo_nxt = 1'b1;                // idle level while released
        end else begin
            if (!act_d_r) begin
                evt_nxt.start = 1'b1;
                // msb must stand before the first sample edge
                sdo_nxt = chr16 ? sh_r[15] : sh_r[7];
            end
            if (smp) begin
                // msb first, shift in while shifting out [R18]
                sh_nxt = {sh_r[14:0], pins.sdi};
                if (cnt_r + 5'h01 == nbits) begin
                    evt_nxt.done = 1'b1;
                    evt_nxt.rx   = chr16 ? {sh_r[14:0], pins.sdi}
                                         : {8'h00, sh_r[6:0], pins.sdi};
                    cnt_nxt = 5'h00;
                end else begin
                    cnt_nxt = cnt_r + 5'h01;
                end
                if (cnt_r == 5'h00 && !act_d_r) begin
                    evt_nxt.start = 1'b1;
                end
            end
            if (shf) begin
                sdo_nxt = chr16 ? sh_r[15] : sh_r[7];
            end
        end
    end

    // registers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sh_r    <= BUF_RST;
            cnt_r   <= 5'h00;
            clk_d_r <= 1'b0;
            act_d_r <= 1'b0;
            sdo_r   <= 1'b1;
            evt_r   <= '0;
        end else begin
            sh_r    <= sh_nxt;
            cnt_r   <= cnt_nxt;
            clk_d_r <= pins.sclk;
            act_d_r <= active;
            sdo_r   <= sdo_nxt;
            evt_r   <= evt_nxt;
        end
    end

    assign sdo = sdo_r;
    assign evt = evt_r;
endmodule
`default_nettype wire

// file: sscc_top.sv
// slave port control and configuration with apb register access
//
// Contract
// R1 - busy set at start, cleared at end
// R2 - complete flag set, cleared by software zero
// R3 - software writing flag one raises interrupt
// R4 - overrun flags second character, newer discarded
// R5 - buffer write while busy sets collision
// R6 - mode fault bits inert in slave mode
// R7 - master bit selects master or slave
// R8 - enable bit turns port on/off
// R9 - interrupt only when enabled and flag set
// R10 - select polarity bit chooses active level
// R11 - reserved config bits read zero, unwritable
// R12 - character length eight or sixteen bits
// R13 - phase bit picks sampling edge
// R14 - polarity bit picks active clock edge
// R15 - clock divider ignored in slave mode
// R16 - busy buffer write blocked, reads free
// R17 - early deselect aborts, nothing loaded
// R18 - msb first full duplex, load buffer
// R19 - deselected: ignore clock, release output
// R20 - pins synchronised before edge detection
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sscc_top import sscc_pkg::*; (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serial_clock_in,
    input  wire logic        slave_select_in,
    input  wire logic        serial_data_in,
    output logic             serial_data_out,
    output logic             serial_data_out_oe_n,  // low while driving
    output logic             port_irq
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] s1_r;          // first stage, read only by second
    logic [2:0] s2_r;          // second stage
    sscc_pins_t pins;

    // two flops per pin before any edge logic [R20]
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            s1_r <= 3'h0;
            s2_r <= 3'h0;
        end else begin
            s1_r <= {serial_clock_in, slave_select_in, serial_data_in};
            s2_r <= s1_r;
        end
    end
    assign pins = sscc_pins_t'(s2_r);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0]  ctrl_r, ctrl_nxt;     // control register
    logic [7:0]  cfg_r, cfg_nxt;       // configuration register
    logic [7:0]  cdiv_r, cdiv_nxt;     // divider, storage only
    logic [15:0] rbuf_r, rbuf_nxt;     // read buffer
    logic        unread_r, unread_nxt; // read buffer holds new data
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt;
    logic        perr_r, perr_nxt;
    logic        irq_r, irq_nxt;
    logic        sdo_oe_n_r, sdo_r;
    logic        selected, active, load, wr, rd, acc, hit;
    logic [7:0]  wb;
    sscc_evt_t   evt;
    logic        sdo_core;

    // ------------------------------------------------------------------
    // port mode and select decode
    // ------------------------------------------------------------------
    always_comb begin
        // polarity chooses active level [R10]
        selected = cfg_r[CFG_SPOL] ? pins.sel : ~pins.sel;
        // slave engine runs only when enabled and not master [R7] [R8]
        // select pin acts as select regardless of fault enable [R6]
        active = ctrl_r[CTL_EN] & ~ctrl_r[CTL_MSTR] & selected;
    end

    // ------------------------------------------------------------------
    // apb access decode (one wait state per access)
    // ------------------------------------------------------------------
    always_comb begin
        acc = psel & penable & ~pready_r;
        wr  = acc & pwrite;
        rd  = acc & ~pwrite;
        wb  = pwdata[7:0];
        hit = (paddr == CTRL_ADDR) || (paddr == CFG_ADDR)
           || (paddr == CLKDIV_ADDR) || (paddr == BUF_ADDR);
        // blocked while busy [R16]
        load = wr && paddr == BUF_ADDR && !ctrl_r[CTL_BUSY];
    end

    // ------------------------------------------------------------------
    // register next state
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_nxt   = ctrl_r;
        cfg_nxt    = cfg_r;
        cdiv_nxt   = cdiv_r;
        rbuf_nxt   = rbuf_r;
        unread_nxt = unread_r;
        prdata_nxt = prdata_r;
        pready_nxt = acc;
        perr_nxt   = acc & ~hit;
        // software writes first, hardware sets override below
        if (wr) begin
            case (paddr)
                CTRL_ADDR: begin
                    // busy stays hardware owned [R1]
                    ctrl_nxt[6:0] = wb[6:0];  // writing one sets [R3]
                end
                CFG_ADDR: begin
                    cfg_nxt = wb & CFG_WMASK;  // [R11]
                end
                CLKDIV_ADDR: begin
                    cdiv_nxt = wb;             // no effect in slave [R15]
                end
                default: begin
                end
            endcase
        end
        if (rd && paddr == BUF_ADDR) begin
            unread_nxt = 1'b0;                 // reads unrestricted [R16]
        end
        // transfer start sets busy [R1]
        if (evt.start) begin
            ctrl_nxt[CTL_BUSY] = 1'b1;
        end
        // abort drops busy, no load, no complete [R17]
        if (evt.abort) begin
            ctrl_nxt[CTL_BUSY] = 1'b0;
        end
        if (evt.done) begin
            ctrl_nxt[CTL_BUSY] = 1'b0;         // [R1]
            ctrl_nxt[CTL_CMPL] = 1'b1;         // set wins over clear [R2]
            if (unread_r && !(rd && paddr == BUF_ADDR)) begin
                ctrl_nxt[CTL_RX_OVERRUN_FLAG] = 1'b1;     // newer discarded [R4]
            end else begin
                rbuf_nxt   = evt.rx;           // load read buffer [R18]
                unread_nxt = 1'b1;
            end
        end
        // buffer write during a transfer [R5] [R16]
        if (wr && paddr == BUF_ADDR && ctrl_r[CTL_BUSY]) begin
            ctrl_nxt[CTL_WRITE_COLLISION_FLAG] = 1'b1;
        end
        if (!ctrl_nxt[CTL_EN]) begin
            ctrl_nxt[CTL_BUSY] = 1'b0;         // disabled port idles [R8]
        end
        // read data mux, narrow registers in low bits
        if (rd) begin
            case (paddr)
                CTRL_ADDR:   prdata_nxt = {24'h000000, ctrl_r};
                CFG_ADDR:    prdata_nxt = {24'h000000, cfg_r & CFG_WMASK};
                CLKDIV_ADDR: prdata_nxt = {24'h000000, cdiv_r};
                BUF_ADDR:    prdata_nxt = {16'h0000, rbuf_r};
                default:     prdata_nxt = 32'h00000000;
            endcase
        end
        // mode fault flag feeds irq; in slave mode only a software write sets it [R6]
        irq_nxt = cfg_nxt[CFG_IRQE] & (ctrl_nxt[CTL_CMPL]
                | ctrl_nxt[CTL_RX_OVERRUN_FLAG] | ctrl_nxt[CTL_WRITE_COLLISION_FLAG]
                | ctrl_nxt[CTL_MODE_FAULT_FLAG]);  // [R9] [R3]
    end

    // register stage
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ctrl_r     <= CTRL_RST;
            cfg_r      <= CFG_RST;
            cdiv_r     <= 8'h00;
            rbuf_r     <= BUF_RST;
            unread_r   <= 1'b0;
            prdata_r   <= 32'h00000000;
            pready_r   <= 1'b0;
            perr_r     <= 1'b0;
            irq_r      <= 1'b0;
            sdo_r      <= 1'b1;
            sdo_oe_n_r <= 1'b1;
        end else begin
            ctrl_r     <= ctrl_nxt;
            cfg_r      <= cfg_nxt;
            cdiv_r     <= cdiv_nxt;
            rbuf_r     <= rbuf_nxt;
            unread_r   <= unread_nxt;
            prdata_r   <= prdata_nxt;
            pready_r   <= pready_nxt;
            perr_r     <= perr_nxt;
            irq_r      <= irq_nxt;
            sdo_r      <= sdo_core;
            sdo_oe_n_r <= ~active;             // release when idle [R19]
        end
    end

    // ------------------------------------------------------------------
    // shift engine
    // ------------------------------------------------------------------
    sscc_shift u_shift (
        .clock   (clock),
        .reset_n (reset_n),
        .pins    (pins),
        .active  (active),
        .cpol    (cfg_r[CFG_POL]),
        .cpha    (cfg_r[CFG_PHA]),
        .chr16   (cfg_r[CFG_CHR]),
        .load    (load),
        .tx_word (pwdata[15:0]),
        .sdo     (sdo_core),
        .evt     (evt)
    );

    assign prdata               = prdata_r;
    assign pready               = pready_r;
    assign pslverr              = perr_r;
    assign port_irq             = irq_r;
    assign serial_data_out      = sdo_r;
    assign serial_data_out_oe_n = sdo_oe_n_r;
endmodule
`default_nettype wire

// file: sscc_checker.sv
// concurrent checks on the ports of the slave port top
`timescale 1ns/1ps
`default_nettype none
module sscc_checker import sscc_pkg::*; (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        serial_clock_in,
    input wire logic        slave_select_in,
    input wire logic        serial_data_in,
    input wire logic        serial_data_out,
    input wire logic        serial_data_out_oe_n,
    input wire logic        port_irq
);
    // ----------------------------------------------------------
    // mirrors of software fields and select dwell counters
    // ----------------------------------------------------------
    logic [7:0] ctl_r, ctl_nxt;   // software side of control
    logic [7:0] cfg_r, cfg_nxt;   // configuration as written
    logic [3:0] off_r, off_nxt;   // cycles not selected
    logic [3:0] on_r,  on_nxt;    // cycles selected
    logic       wr_t;             // write taken this edge
    logic       act;              // enabled slave and selected
    // next values: writes land at the taking edge
    always_comb begin
        wr_t = psel && penable && pwrite && !pready;
        ctl_nxt = ctl_r;
        cfg_nxt = cfg_r;
        if (wr_t && paddr == CTRL_ADDR) ctl_nxt = pwdata[7:0];
        if (wr_t && paddr == CFG_ADDR) cfg_nxt = pwdata[7:0] & CFG_WMASK;
        act = ctl_r[CTL_EN] && !ctl_r[CTL_MSTR]
            && (slave_select_in == cfg_r[CFG_SPOL]);
        // saturate so a long idle never wraps to look fresh
        off_nxt = act ? 4'h0 : ((off_r == 4'hF) ? 4'hF : off_r + 4'h1);
        on_nxt = !act ? 4'h0 : ((on_r == 4'hF) ? 4'hF : on_r + 4'h1);
    end
    // register the helper state
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ctl_r <= 8'h00;
            cfg_r <= 8'h00;
            off_r <= 4'h0;
            on_r  <= 4'h0;
        end else begin
            ctl_r <= ctl_nxt;
            cfg_r <= cfg_nxt;
            off_r <= off_nxt;
            on_r  <= on_nxt;
        end
    end
    // ----------------------------------------------------------
    // properties
    // ----------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence s_take;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_ready_wait: assert property (s_take |=> s_answer)
        else $error("access not answered after one wait state");
    a_slverr_map: assert property (pready |-> pslverr == !(paddr == CTRL_ADDR
        || paddr == CFG_ADDR || paddr == CLKDIV_ADDR || paddr == BUF_ADDR))
        else $error("slave error does not match address map");
    a_cfg_read: assert property (
        pready && !pwrite && paddr == CFG_ADDR |-> prdata == {24'h0, cfg_r})
        else $error("configuration read differs from written value");
    a_ctl_soft: assert property (
        pready && !pwrite && paddr == CTRL_ADDR
        |-> prdata[3:0] == ctl_r[3:0] && prdata[31:8] == 24'h0)
        else $error("control software bits read back wrong");
    a_irq_mask: assert property (
        !cfg_r[CFG_IRQE] && !$past(cfg_r[CFG_IRQE]) |-> !port_irq)
        else $error("interrupt raised while masked");
    a_irq_soft: assert property (
        wr_t && paddr == CTRL_ADDR && |pwdata[6:3] && cfg_r[CFG_IRQE]
        |-> ##[1:3] port_irq)
        else $error("software flag write raised no interrupt");
    a_release_idle: assert property (
        off_r >= 4'h8 |-> serial_data_out_oe_n && serial_data_out)
        else $error("data output driven while not selected");
    a_drive_sel: assert property (
        on_r >= 4'h8 |-> !serial_data_out_oe_n)
        else $error("data output not driven while selected");
endmodule
`default_nettype wire

// file: sscc_spi_master.sv
// behavioural external master driving clock, select and data
`timescale 1ns/1ps
`default_nettype none
module sscc_spi_master (
    output logic      sclk,
    output logic      ss,
    output logic      mosi,
    input  wire logic miso
);
    initial begin
        sclk = 1'b0;
        ss   = 1'b1;
        mosi = 1'b0;
    end
    // park clock and select at the idle levels of a format
    task idle(input logic pol, input logic spol);
        sclk = pol;
        ss   = ~spol;
    endtask
    // one frame, msb first; nb below character length aborts it
    task xfer(input logic [15:0] tx, input int nb, input logic pol,
              input logic pha, input logic spol, input int hp,
              output logic [15:0] rx);
        int i;
        rx = 16'h0000;
        #2;
        idle(pol, spol);
        #100;
        ss = spol;
        #100;
        for (i = 0; i < nb; i++) begin
            if (!pha) mosi = tx[15-i];
            #hp;
            sclk = ~pol;
            if (pha) mosi = tx[15-i];
            else rx = {rx[14:0], miso};
            #hp;
            sclk = pol;
            if (pha) rx = {rx[14:0], miso};
        end
        #hp;
        ss = ~spol;
        mosi = ~mosi;                        // released line toggles
        #100;
    endtask
endmodule
`default_nettype wire

// file: spi_slave_control_config_tb.sv
// self-checking bench for the slave port control block
`timescale 1ns/1ps
`default_nettype none
module spi_slave_control_config_tb import sscc_pkg::*;;
    logic        clock, reset_n, psel, penable, pwrite, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, irq, sdo, oe_n, sclk, ss, mosi;
    logic [15:0] rx, m;
    logic [7:0]  cf;
    logic [3:0]  i;
    int          failures, compares;
    wire logic   miso;
    assign miso = oe_n ? 1'b1 : sdo;  // weak pull-up when released
    sscc_top dut (.clock(clock), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_clock_in(sclk), .slave_select_in(ss),
        .serial_data_in(mosi), .serial_data_out(sdo),
        .serial_data_out_oe_n(oe_n), .port_irq(irq));
    sscc_spi_master master (.sclk(sclk), .ss(ss), .mosi(mosi),
        .miso(miso));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ----------------------------------------------------------
    // tasks
    // ----------------------------------------------------------
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            failures++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask
    // one apb transfer; waits for pready under a bound
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input string n, input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(n, q, x);
    endtask
    // disable, park pins, configure, enable as slave
    task setup(input logic [7:0] c);
        apb(1'b1, CTRL_ADDR, 32'h0);
        master.idle(c[CFG_POL], c[CFG_SPOL]);
        cf = c;
        apb(1'b1, CFG_ADDR, {24'h0, c});
        apb(1'b1, CTRL_ADDR, 32'h05);
    endtask
    task go(input logic [15:0] d, input int nb, input int hp);
        master.xfer(d, nb, cf[CFG_POL], cf[CFG_PHA], cf[CFG_SPOL], hp, rx);
    endtask
    task results;
        if (failures == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #500000;
        failures++;
        results();
    end
    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        failures = 0;
        compares = 0;
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        rd("ctrl_reset", CTRL_ADDR, 32'h0);
        rd("cfg_reset", CFG_ADDR, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk("slverr", e, 1'b1);
        apb(1'b1, CFG_ADDR, 32'hFF);
        rd("cfg_rsvd", CFG_ADDR, 32'hC7);
        apb(1'b1, CTRL_ADDR, 32'h80);
        rd("busy_ro", CTRL_ADDR, 32'h0);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, CFG_ADDR, 32'h0);
            apb(1'b1, CTRL_ADDR, 32'h08 << i);
            repeat (3) @(posedge clock);
            chk("irq_mask", irq, 1'b0);
            apb(1'b1, CTRL_ADDR, 32'h0);
            apb(1'b1, CFG_ADDR, 32'h80);
            apb(1'b1, CTRL_ADDR, 32'h08 << i);
            repeat (3) @(posedge clock);
            chk("irq_soft", irq, 1'b1);
            apb(1'b1, CTRL_ADDR, 32'h0);
            repeat (3) @(posedge clock);
            chk("irq_clear", irq, 1'b0);
        end
        // every polarity, phase, length and select level
        for (i = 0; i < 8; i++) begin
            setup({i[0], i[0] ^ i[1], 3'b000, i[2:0]});
            m = 16'h5A3C + {12'h000, i};
            apb(1'b1, BUF_ADDR, {16'h0, ~m});
            go(m, i[2] ? 16 : 8, 60);
            rd("ctrl_done", CTRL_ADDR, 32'h45);
            chk("irq_done", irq, i[0]);
            rd("rx_buf", BUF_ADDR,
               i[2] ? {16'h0, m} : {24'h0, m[15:8]});
            chk("miso", rx, i[2] ? {~m} : {8'h00, ~m[7:0]});
        end
        setup(8'h04);
        go(16'h1234, 16, 60);
        go(16'h5678, 16, 60);
        rd("ctrl_ovr", CTRL_ADDR, 32'h65);
        rd("buf_ovr", BUF_ADDR, 32'h1234);
        setup(8'h04);
        apb(1'b1, BUF_ADDR, 32'h0F0F);
        fork
            go(16'h0000, 16, 150);
            begin
                repeat (60) @(posedge clock);
                apb(1'b1, BUF_ADDR, 32'hBEEF);
            end
        join
        rd("ctrl_write_collision_flag", CTRL_ADDR, 32'h55);
        chk("tx_kept", rx, 16'h0F0F);
        setup(8'h00);
        go(16'hFF00, 5, 60);
        rd("ctrl_abort", CTRL_ADDR, 32'h05);
        rd("buf_abort", BUF_ADDR, 32'h0);
        go(16'h9600, 8, 60);
        rd("ctrl_after", CTRL_ADDR, 32'h45);
        rd("buf_after", BUF_ADDR, 32'h96);
        apb(1'b1, CLKDIV_ADDR, 32'hFF);
        for (i = 0; i < 2; i++) begin
            apb(1'b1, CTRL_ADDR, i[0] ? 32'h03 : 32'h00);
            go(16'hAA00, 8, 60);
            chk("no_reply", rx, 16'h00FF);
            rd("ctrl_quiet", CTRL_ADDR, i[0] ? 32'h03 : 32'h00);
        end
        results();
    end
endmodule
bind sscc_top sscc_checker u_chk (.clock(clock), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_in(serial_clock_in), .slave_select_in(slave_select_in),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_out_oe_n(serial_data_out_oe_n), .port_irq(port_irq));
`default_nettype wire
